// [odc_cond_eval.sv]
// Condition evaluator for conditional branches and jumps.
// Assumes flags are stable in the cycle they are tested; no clock here.
`timescale 1ns/1ps
module odc_cond_eval
  import odc_pkg::*;
(
  odc_cond_if.eval cif
);

  logic base;

  // Low three bits pick the test, the top bit inverts it
  always_comb begin
    unique case (cif.condition_field[2:0])
      3'h0: base = 1'b0;
      3'h1: base = cif.s ^ cif.v;
      3'h2: base = cif.z | (cif.s ^ cif.v);
      3'h3: base = cif.c | cif.z;
      3'h4: base = cif.v;
      3'h5: base = cif.s;
      3'h6: base = cif.z;
      3'h7: base = cif.c;
    endcase
  end

  assign cif.take = base ^ cif.condition_field[3];

endmodule : odc_cond_eval

// [odc_cond_if.sv]
// Carries a condition field and the four test flags to the evaluator and its verdict back.
// Assumes the evaluator is purely combinational.
`timescale 1ns/1ps
interface odc_cond_if;
  logic [3:0] condition_field;
  logic c;
  logic z;
  logic s;
  logic v;
  logic take;

  modport eval (input condition_field, input c, input z, input s, input v, output take);
  modport user (output condition_field, output c, output z, output s, output v, input take);
endinterface : odc_cond_if

// [odc_decode.sv]
// Upper-half opcode decoder, condition test and add-with-carry execution unit.
// Assumes fetch presents one opcode per op_valid pulse and the register file supplies operands.
`timescale 1ns/1ps
module odc_decode
  import odc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire odc_flags_t flags_in,
  input wire logic adc_go,
  input wire logic [7:0] adc_dst,
  input wire logic [7:0] adc_src,
  output odc_instr_t dec_instr_q,
  output logic dec_valid_q,
  output logic [3:0] dec_reg_num_q,
  output logic [3:0] dec_condition_field_q,
  output logic dec_take_q,
  output logic [1:0] dec_bytes_q,
  output logic [3:0] dec_cycles_q,
  output logic dec_src_first_q,
  output logic adc_done_q,
  output logic [7:0] adc_result_q,
  output odc_flags_t adc_flags_q
);

  // ==========================================
  // Condition evaluation
  odc_cond_if cif ();

  assign cif.condition_field = opcode[7:4];
  assign cif.c = flags_in.c;
  assign cif.z = flags_in.z;
  assign cif.s = flags_in.s;
  assign cif.v = flags_in.v;

  odc_cond_eval u_eval (
    .cif(cif)
  );

  // ==========================================
  // Opcode decode
  function automatic odc_instr_t misc_decode(input logic [3:0] hi);
    odc_instr_t r;
    r = ODC_I_NO_OPERATION;
    unique case (hi)
      4'h0: r = ODC_I_THREAD_NEXT;
      4'h1: r = ODC_I_THREAD_ENTER;
      4'h2: r = ODC_I_THREAD_EXIT;
      4'h3: r = ODC_I_WAIT_FOR_INTERRUPT;
      4'h4: r = ODC_I_BANK_SELECT_ZERO;
      4'h5: r = ODC_I_BANK_SELECT_ONE;
      4'h6: r = ODC_I_IDLE;
      4'h7: r = ODC_I_STOP;
      4'h8: r = ODC_I_INTERRUPT_DISABLE;
      4'h9: r = ODC_I_INTERRUPT_ENABLE;
      4'ha: r = ODC_I_SUBROUTINE_RETURN;
      4'hb: r = ODC_I_INTERRUPT_RETURN;
      4'hc: r = ODC_I_CLEAR_CARRY;
      4'hd: r = ODC_I_SET_CARRY;
      4'he: r = ODC_I_COMPLEMENT_CARRY;
      4'hf: r = ODC_I_NO_OPERATION;
    endcase
    return r;
  endfunction : misc_decode

  odc_instr_t instr_d;
  logic dec_valid_d;
  logic [3:0] reg_num_d;
  logic [3:0] cond_d;
  logic take_d;
  logic [1:0] bytes_d;
  logic [3:0] cycles_d;
  logic src_first_d;

  always_comb begin
    instr_d = dec_instr_q;
    dec_valid_d = op_valid;
    reg_num_d = dec_reg_num_q;
    cond_d = dec_condition_field_q;
    take_d = dec_take_q;
    bytes_d = dec_bytes_q;
    cycles_d = dec_cycles_q;
    src_first_d = dec_src_first_q;
    if (op_valid) begin
      reg_num_d = opcode[7:4];
      cond_d = opcode[7:4];
      take_d = 1'b0;
      bytes_d = 2'h0;
      cycles_d = 4'h0;
      src_first_d = 1'b0;
      unique case (opcode[3:0])
        ODC_COL_LD_WR: instr_d = ODC_I_LOAD_MOVE_WR;
        ODC_COL_LD_RW: instr_d = ODC_I_LOAD_MOVE_RW;
        ODC_COL_DBNZ: instr_d = ODC_I_DECREMENT_BRANCH_NONZERO;
        ODC_COL_RBR: begin
          instr_d = ODC_I_CONDITIONAL_RELATIVE_BRANCH;
          take_d = cif.take;
        end
        ODC_COL_LDI: instr_d = ODC_I_LOAD_MOVE_IMM;
        ODC_COL_AJMP: begin
          instr_d = ODC_I_CONDITIONAL_ABSOLUTE_JUMP;
          take_d = cif.take;
        end
        ODC_COL_INCW: instr_d = ODC_I_INC_WORKING;
        ODC_COL_MISC: instr_d = misc_decode(opcode[7:4]);
        default: begin
          instr_d = ODC_I_OTHER;
          unique case (opcode)
            ODC_OP_ADC_RR: begin
              instr_d = ODC_I_ADC;
              bytes_d = ODC_BYTES_SHORT;
              cycles_d = ODC_CYC_FAST;
            end
            ODC_OP_ADC_RIR: begin
              instr_d = ODC_I_ADC;
              bytes_d = ODC_BYTES_SHORT;
              cycles_d = ODC_CYC_SLOW;
            end
            ODC_OP_ADC_GG, ODC_OP_ADC_GIG: begin
              instr_d = ODC_I_ADC;
              bytes_d = ODC_BYTES_LONG;
              cycles_d = ODC_CYC_SLOW;
              src_first_d = 1'b1;
            end
            ODC_OP_ADC_GIM: begin
              instr_d = ODC_I_ADC;
              bytes_d = ODC_BYTES_LONG;
              cycles_d = ODC_CYC_SLOW;
            end
            default: instr_d = ODC_I_OTHER;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_instr_q <= ODC_I_OTHER;
      dec_valid_q <= 1'b0;
      dec_reg_num_q <= 4'h0;
      dec_condition_field_q <= 4'h0;
      dec_take_q <= 1'b0;
      dec_bytes_q <= 2'h0;
      dec_cycles_q <= 4'h0;
      dec_src_first_q <= 1'b0;
    end else begin
      dec_instr_q <= instr_d;
      dec_valid_q <= dec_valid_d;
      dec_reg_num_q <= reg_num_d;
      dec_condition_field_q <= cond_d;
      dec_take_q <= take_d;
      dec_bytes_q <= bytes_d;
      dec_cycles_q <= cycles_d;
      dec_src_first_q <= src_first_d;
    end
  end

  // ==========================================
  // Add-with-carry execution
  // The source is only read, never written back: the caller keeps it untouched
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] result_d;
  odc_flags_t flags_d;
  logic done_d;

  always_comb begin
    sum9 = {1'b0, adc_dst} + {1'b0, adc_src} + {8'h00, flags_in.c};
    sum5 = {1'b0, adc_dst[3:0]} + {1'b0, adc_src[3:0]} + {4'h0, flags_in.c};
    result_d = adc_result_q;
    flags_d = adc_flags_q;
    done_d = adc_go;
    if (adc_go) begin
      result_d = sum9[7:0];
      flags_d.c = sum9[8];
      flags_d.z = (sum9[7:0] == ODC_RST_BYTE);
      flags_d.s = sum9[7];
      flags_d.v = (adc_dst[7] == adc_src[7]) && (sum9[7] != adc_dst[7]);
      flags_d.d = 1'b0;
      flags_d.h = sum5[4];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_result_q <= 8'h00;
      adc_flags_q <= '0;
      adc_done_q <= 1'b0;
    end else begin
      adc_result_q <= result_d;
      adc_flags_q <= flags_d;
      adc_done_q <= done_d;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_branch_in;
    op_valid && (opcode[3:0] == ODC_COL_RBR || opcode[3:0] == ODC_COL_AJMP);
  endsequence

  sequence s_adc_in;
    adc_go;
  endsequence

  chk_false_never: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_FALSE)
    |=> dec_valid_q && !dec_take_q) else $error("false condition took a jump");
  chk_true_always: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_TRUE)
    |=> dec_take_q) else $error("true condition did not jump");
  chk_carry_cond: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_UGE)
    |=> dec_take_q == !$past(flags_in.c)) else $error("no-carry test wrong");
  chk_zero_cond: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_ZERO)
    |=> dec_take_q == $past(flags_in.z)) else $error("zero test wrong");
  chk_signed_gt: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_SGT)
    |=> dec_take_q == !($past(flags_in.z) | ($past(flags_in.s) ^ $past(flags_in.v))))
    else $error("signed greater-than test wrong");
  chk_unsigned_gt: assert property (s_branch_in and (op_valid && opcode[7:4] == ODC_CC_UGT)
    |=> dec_take_q == (!$past(flags_in.c) && !$past(flags_in.z))) else $error("unsigned gt wrong");
  chk_nop_decode: assert property (op_valid && opcode == 8'hff
    |=> dec_instr_q == ODC_I_NO_OPERATION) else $error("no-operation misdecoded");
  chk_column_jump: assert property (op_valid && opcode[3:0] == ODC_COL_AJMP
    |=> dec_instr_q == ODC_I_CONDITIONAL_ABSOLUTE_JUMP && dec_condition_field_q == $past(opcode[7:4]))
    else $error("absolute jump column misdecoded");
  chk_adc_sum: assert property (s_adc_in |=> adc_done_q
    && adc_result_q == 8'($past(adc_dst) + $past(adc_src) + {7'h00, $past(flags_in.c)}))
    else $error("add-with-carry sum wrong");
  chk_adc_flags: assert property (s_adc_in |=> adc_flags_q.z == (adc_result_q == 8'h00)
    && adc_flags_q.s == adc_result_q[7] && !adc_flags_q.d) else $error("add-with-carry flags wrong");
  chk_adc_long: assert property (op_valid && opcode == ODC_OP_ADC_GG
    |=> dec_bytes_q == ODC_BYTES_LONG && dec_cycles_q == ODC_CYC_SLOW && dec_src_first_q)
    else $error("register-register form misdecoded");

endmodule : odc_decode

// [odc_decode_tb_top.sv]
// Self-checking bench for the upper-half opcode decoder with its condition test and add-with-carry unit.
// Assumes odc_pkg and the design files are compiled first; the bench drives every design port itself.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module odc_decode_tb_top;
  import odc_pkg::*;

  // ==========================================
  // Signals and instance
  logic sys_clk;
  logic sys_rst;
  logic op_valid;
  logic [7:0] opcode;
  odc_flags_t flags_in;
  logic adc_go;
  logic [7:0] adc_dst;
  logic [7:0] adc_src;
  odc_instr_t dec_instr_q;
  logic dec_valid_q;
  logic [3:0] dec_reg_num_q;
  logic [3:0] dec_condition_field_q;
  logic dec_take_q;
  logic [1:0] dec_bytes_q;
  logic [3:0] dec_cycles_q;
  logic dec_src_first_q;
  logic adc_done_q;
  logic [7:0] adc_result_q;
  odc_flags_t adc_flags_q;
  int mismatches = 0;
  int tests_run = 0;

  odc_decode uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid), .opcode(opcode),
    .flags_in(flags_in), .adc_go(adc_go), .adc_dst(adc_dst), .adc_src(adc_src),
    .dec_instr_q(dec_instr_q), .dec_valid_q(dec_valid_q), .dec_reg_num_q(dec_reg_num_q),
    .dec_condition_field_q(dec_condition_field_q), .dec_take_q(dec_take_q), .dec_bytes_q(dec_bytes_q),
    .dec_cycles_q(dec_cycles_q), .dec_src_first_q(dec_src_first_q), .adc_done_q(adc_done_q),
    .adc_result_q(adc_result_q), .adc_flags_q(adc_flags_q));

  // ==========================================
  // Rows: add-with-carry formats and sums
  typedef struct packed {logic [7:0] op; logic [1:0] bytes; logic [3:0] cyc; logic src_first;} odc_fmt_row_t;
  typedef struct packed {logic [7:0] dst; logic [7:0] src; logic cin; logic [7:0] res;} odc_sum_row_t;
  odc_fmt_row_t fmt_rows [5] = '{'{8'h12, 2'h2, 4'h4, 1'b0}, '{8'h13, 2'h2, 4'h6, 1'b0},
    '{8'h14, 2'h3, 4'h6, 1'b1}, '{8'h15, 2'h3, 4'h6, 1'b1}, '{8'h16, 2'h3, 4'h6, 1'b0}};
  // Edge sums: carry-in only, sign overflow, wrap to zero, half-carry alone
  odc_sum_row_t sum_rows [7] = '{'{8'h10, 8'h03, 1'b1, 8'h14}, '{8'h7f, 8'h00, 1'b1, 8'h80},
    '{8'hff, 8'h00, 1'b1, 8'h00}, '{8'h80, 8'h80, 1'b0, 8'h00}, '{8'h08, 8'h08, 1'b0, 8'h10},
    '{8'h0f, 8'h00, 1'b1, 8'h10}, '{8'h12, 8'h03, 1'b0, 8'h15}};

  // ==========================================
  // Reference models
  function automatic logic cond_ref(input logic [3:0] cc, input logic c, input logic z, input logic s,
                                    input logic v);
    logic r;
    case (cc[2:0])
      3'h0: r = 1'b0;
      3'h1: r = s ^ v;
      3'h2: r = z | (s ^ v);
      3'h3: r = c | z;
      3'h4: r = v;
      3'h5: r = s;
      3'h6: r = z;
      default: r = c;
    endcase
    // Upper bit of the field inverts the test
    return cc[3] ? !r : r;
  endfunction : cond_ref

  function automatic odc_instr_t instr_ref(input logic [7:0] op);
    case (op[3:0])
      4'h8: return ODC_I_LOAD_MOVE_WR;
      4'h9: return ODC_I_LOAD_MOVE_RW;
      4'ha: return ODC_I_DECREMENT_BRANCH_NONZERO;
      4'hb: return ODC_I_CONDITIONAL_RELATIVE_BRANCH;
      4'hc: return ODC_I_LOAD_MOVE_IMM;
      4'hd: return ODC_I_CONDITIONAL_ABSOLUTE_JUMP;
      4'he: return ODC_I_INC_WORKING;
      4'hf: return odc_instr_t'({2'b00, op[7:4]} + 6'h08);
      default: return (op >= 8'h12 && op <= 8'h16) ? ODC_I_ADC : ODC_I_OTHER;
    endcase
  endfunction : instr_ref

  // ==========================================
  // Drivers
  task automatic dec_op(input logic [7:0] op, input logic [3:0] fl);
    logic [3:0] lo;
    logic cond_col;
    logic exp_take;
    odc_instr_t ei;
    lo = op[3:0];
    ei = instr_ref(op);
    cond_col = (lo == 4'hb) || (lo == 4'hd);
    exp_take = cond_col ? cond_ref(op[7:4], fl[3], fl[2], fl[1], fl[0]) : 1'b0;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    opcode <= op;
    flags_in <= odc_flags_t'({fl, 2'b11});
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    `CHK(dec_valid_q, 1'b1)
    `CHK(dec_instr_q, ei)
    `CHK(dec_take_q, exp_take)
    if (lo >= 4'h8 && lo != 4'hf) `CHK(dec_reg_num_q, op[7:4])
    if (cond_col) `CHK(dec_condition_field_q, op[7:4])
    if (ei !== ODC_I_ADC) `CHK({dec_bytes_q, dec_cycles_q}, 6'h00)
  endtask : dec_op

  task automatic adc_op(input logic [7:0] d, input logic [7:0] s, input logic cin, input logic [7:0] res);
    logic [8:0] sum;
    logic [4:0] low;
    odc_flags_t ef;
    sum = {1'b0, d} + {1'b0, s} + {8'h00, cin};
    low = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
    ef = '{c: sum[8], z: (sum[7:0] == 8'h00), s: sum[7], v: (d[7] == s[7]) && (sum[7] != d[7]),
           d: 1'b0, h: low[4]};
    @(posedge sys_clk);
    adc_go <= 1'b1;
    adc_dst <= d;
    adc_src <= s;
    // Decimal-adjust and half-carry set on entry so a stale copy shows up
    flags_in <= odc_flags_t'({cin, 5'b00011});
    @(posedge sys_clk);
    adc_go <= 1'b0;
    #1;
    `CHK(adc_done_q, 1'b1)
    `CHK(adc_result_q, res)
    `CHK(adc_flags_q, ef)
    @(posedge sys_clk);
    #1;
    `CHK(adc_done_q, 1'b0)
  endtask : adc_op

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Full sweep takes about 8,240 cycles; allow a wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    op_valid = 1'b0;
    opcode = 8'h00;
    flags_in = '0;
    adc_go = 1'b0;
    adc_dst = 8'h00;
    adc_src = 8'h00;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (fmt_rows[i]) begin
      dec_op(fmt_rows[i].op, 4'h0);
      `CHK({dec_bytes_q, dec_cycles_q}, {fmt_rows[i].bytes, fmt_rows[i].cyc})
      `CHK(dec_src_first_q, fmt_rows[i].src_first)
    end
    foreach (sum_rows[i]) adc_op(sum_rows[i].dst, sum_rows[i].src, sum_rows[i].cin, sum_rows[i].res);
    // Every opcode against every combination of the four tested flags
    for (int i = 0; i < 256; i++) begin
      for (int f = 0; f < 16; f++) dec_op(8'(i), 4'(f));
    end
    // Back to back: two opcodes and two sums on consecutive edges, both units at once
    @(posedge sys_clk);
    op_valid <= 1'b1;
    opcode <= 8'hbd;
    flags_in <= odc_flags_t'(6'b000000);
    adc_go <= 1'b1;
    adc_dst <= 8'hff;
    adc_src <= 8'h01;
    @(posedge sys_clk);
    opcode <= 8'h1f;
    adc_dst <= 8'h01;
    adc_src <= 8'h01;
    #1;
    `CHK({dec_valid_q, dec_take_q, dec_instr_q}, {2'b11, ODC_I_CONDITIONAL_ABSOLUTE_JUMP})
    `CHK({adc_done_q, adc_result_q}, 9'h100)
    @(posedge sys_clk);
    op_valid <= 1'b0;
    adc_go <= 1'b0;
    #1;
    `CHK({dec_valid_q, dec_instr_q}, {1'b1, ODC_I_THREAD_ENTER})
    `CHK({adc_done_q, adc_result_q}, 9'h102)
    @(posedge sys_clk);
    #1;
    `CHK({dec_valid_q, dec_instr_q}, {1'b0, ODC_I_THREAD_ENTER})
    // Reset in mid-run clears everything at once, then decoding resumes
    sys_rst <= 1'b1;
    #2;
    `CHK({dec_instr_q, dec_take_q, adc_result_q, adc_flags_q}, {ODC_I_OTHER, 15'h0000})
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    dec_op(8'h8b, 4'h0);
    test_done();
  end
endmodule : odc_decode_tb_top

// [odc_pkg.sv]
// Constants and types shared by the upper-half opcode decoder and its condition evaluator.
// Assumes a single core clock; nothing here holds state.
package odc_pkg;

  // ==========================================
  // Opcode fields
  localparam int ODC_NIB_W = 4;
  localparam int ODC_BYTE_W = 8;

  // Lower-nibble columns of the upper decode half
  localparam logic [3:0] ODC_COL_LD_WR = 4'h8;
  localparam logic [3:0] ODC_COL_LD_RW = 4'h9;
  localparam logic [3:0] ODC_COL_DBNZ = 4'ha;
  localparam logic [3:0] ODC_COL_RBR = 4'hb;
  localparam logic [3:0] ODC_COL_LDI = 4'hc;
  localparam logic [3:0] ODC_COL_AJMP = 4'hd;
  localparam logic [3:0] ODC_COL_INCW = 4'he;
  localparam logic [3:0] ODC_COL_MISC = 4'hf;

  // Add-with-carry opcodes
  localparam logic [7:0] ODC_OP_ADC_RR = 8'h12;
  localparam logic [7:0] ODC_OP_ADC_RIR = 8'h13;
  localparam logic [7:0] ODC_OP_ADC_GG = 8'h14;
  localparam logic [7:0] ODC_OP_ADC_GIG = 8'h15;
  localparam logic [7:0] ODC_OP_ADC_GIM = 8'h16;

  // Lengths and cycle counts of the add-with-carry formats
  localparam logic [1:0] ODC_BYTES_SHORT = 2'h2;
  localparam logic [1:0] ODC_BYTES_LONG = 2'h3;
  localparam logic [3:0] ODC_CYC_FAST = 4'h4;
  localparam logic [3:0] ODC_CYC_SLOW = 4'h6;

  // ==========================================
  // Condition codes
  localparam logic [3:0] ODC_CC_FALSE = 4'h0;
  localparam logic [3:0] ODC_CC_TRUE = 4'h8;
  localparam logic [3:0] ODC_CC_ULT = 4'h7;
  localparam logic [3:0] ODC_CC_UGE = 4'hf;
  localparam logic [3:0] ODC_CC_ZERO = 4'h6;
  localparam logic [3:0] ODC_CC_NZ = 4'he;
  localparam logic [3:0] ODC_CC_PLUS = 4'hd;
  localparam logic [3:0] ODC_CC_MINUS = 4'h5;
  localparam logic [3:0] ODC_CC_OV = 4'h4;
  localparam logic [3:0] ODC_CC_NOV = 4'hc;
  localparam logic [3:0] ODC_CC_SGE = 4'h9;
  localparam logic [3:0] ODC_CC_SLT = 4'h1;
  localparam logic [3:0] ODC_CC_SGT = 4'ha;
  localparam logic [3:0] ODC_CC_SLE = 4'h2;
  localparam logic [3:0] ODC_CC_UGT = 4'hb;
  localparam logic [3:0] ODC_CC_ULE = 4'h3;

  // ==========================================
  // Reset values
  localparam logic [7:0] ODC_RST_BYTE = 8'h00;

  typedef enum logic [5:0] {
    ODC_I_OTHER = 6'h00,
    ODC_I_LOAD_MOVE_WR = 6'h01,
    ODC_I_LOAD_MOVE_RW = 6'h02,
    ODC_I_DECREMENT_BRANCH_NONZERO = 6'h03,
    ODC_I_CONDITIONAL_RELATIVE_BRANCH = 6'h04,
    ODC_I_LOAD_MOVE_IMM = 6'h05,
    ODC_I_CONDITIONAL_ABSOLUTE_JUMP = 6'h06,
    ODC_I_INC_WORKING = 6'h07,
    ODC_I_THREAD_NEXT = 6'h08,
    ODC_I_THREAD_ENTER = 6'h09,
    ODC_I_THREAD_EXIT = 6'h0a,
    ODC_I_WAIT_FOR_INTERRUPT = 6'h0b,
    ODC_I_BANK_SELECT_ZERO = 6'h0c,
    ODC_I_BANK_SELECT_ONE = 6'h0d,
    ODC_I_IDLE = 6'h0e,
    ODC_I_STOP = 6'h0f,
    ODC_I_INTERRUPT_DISABLE = 6'h10,
    ODC_I_INTERRUPT_ENABLE = 6'h11,
    ODC_I_SUBROUTINE_RETURN = 6'h12,
    ODC_I_INTERRUPT_RETURN = 6'h13,
    ODC_I_CLEAR_CARRY = 6'h14,
    ODC_I_SET_CARRY = 6'h15,
    ODC_I_COMPLEMENT_CARRY = 6'h16,
    ODC_I_NO_OPERATION = 6'h17,
    ODC_I_ADC = 6'h18
  } odc_instr_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } odc_flags_t;

endpackage : odc_pkg
